// file: srap_assertions.sv
// Pin checks between the host and device ends.
// Assumes one bus clock and a strap held still while out of reset.
`timescale 1ns/1ns
module srap_assertions import srap_pkg::*; (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Host pins
    input wire logic bus_style_select,
    input wire logic reg_port_sel_n,
    input wire logic shared_memory_request_n,
    input wire logic [SRAP_ADDR_W-1:0] reg_addr_lines,
    input wire logic slave_data_strobe_n,
    input wire logic slave_dir,
    // Device pins
    input wire logic dev_data_oe,
    input wire logic [1:0] size_ack_seen_n,
    input wire logic ready_seen
);
    logic ack_on;
    logic is_rd;
    // Ack of the strapped style; the other style's pin must stay quiet
    assign ack_on = bus_style_select ? (size_ack_seen_n == SRAP_SIZE_ACK_ON) : ready_seen;
    assign is_rd = (slave_dir == bus_style_select);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // ****
    // Steps of one access
    // ****
    sequence s_strobe_open;
        $fell(slave_data_strobe_n) && !reg_port_sel_n;
    endsequence
    sequence s_ack_start;
        $rose(ack_on);
    endsequence
    // Bound covers two sync flops plus the read turnaround
    a_strobe_gets_ack: assert property (s_strobe_open |-> ##[1:8] ack_on)
        else $error("data strobe not acknowledged in time");
    a_ack_needs_sel: assert property (s_ack_start |-> !reg_port_sel_n && !slave_data_strobe_n)
        else $error("ack without select and strobe");
    a_read_drives_data: assert property (s_ack_start and is_rd |-> dev_data_oe)
        else $error("read ack without data");
    a_write_no_drive: assert property (s_ack_start and !is_rd |-> !dev_data_oe)
        else $error("device drives data on write");
    a_ack_release: assert property ($rose(slave_data_strobe_n) |-> ##[1:5] !ack_on)
        else $error("ack held after strobe release");
    a_ack_style_pins: assert property (bus_style_select ? !ready_seen :
        size_ack_seen_n == SRAP_SIZE_ACK_OFF)
        else $error("wrong ack pin for style");
    a_no_overlap: assert property (reg_port_sel_n || shared_memory_request_n)
        else $error("select and memory request overlap");
    a_gap_after_sel: assert property ($rose(reg_port_sel_n) |-> shared_memory_request_n [*2])
        else $error("memory request too soon after select");
    a_gap_after_mem: assert property ($rose(shared_memory_request_n) |-> reg_port_sel_n [*2])
        else $error("select too soon after memory request");
    a_addr_held: assert property (!slave_data_strobe_n && !ack_on |=>
        $stable(reg_addr_lines) && $stable(slave_dir))
        else $error("address or direction moved in access");
endmodule : srap_assertions

// file: srap_device.sv
// Register access port slave: the device end of the host register port.
// Assumes the host keeps select and shared memory request apart and spaced.
//
// Contract
// - Access only while active-low select is low
// - Register chosen from six address lines
// - Host never overlaps select and memory request
// - Host leaves two clocks between the two
// - Style 1 latches address on strobe fall
// - Style 0 latches address on strobe rise
// - Data sampled or driven only under strobe
// - Style 1 direction high reads, low writes
// - Style 0 direction low reads, high writes
// - Host drives register address on every access
// - Style 1 ends cycle with size acks low
// - Style 0 ends cycle with ready asserted
`timescale 1ns/1ns
module srap_device import srap_pkg::*; #(
    parameter int ADDR_W = SRAP_ADDR_W,
    parameter int DATA_W = SRAP_DATA_W
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Host-facing pins
    srap_if.device bus,
    // Register file side
    output logic [ADDR_W-1:0] REG_ADDR,
    output logic REG_WR_STB,
    output logic [DATA_W-1:0] REG_WR_DATA,
    output logic REG_RD_STB,
    input wire logic [DATA_W-1:0] REG_RD_DATA,
    // Diagnostics
    output logic PORT_CONFLICT
);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic sel_s1_r;
    logic sel_s2_r;
    logic shared_memory_request_s1_r;
    logic shared_memory_request_s2_r;
    logic sas_s1_r;
    logic sas_s2_r;
    logic sas_s3_r;
    logic sds_s1_r;
    logic sds_s2_r;
    logic dir_s1_r;
    logic dir_s2_r;
    logic [ADDR_W-1:0] addr_s1_r;
    logic [ADDR_W-1:0] addr_s2_r;
    logic style;

    // Strap is static, so it is used as is
    assign style = bus.bus_style_select;

    // Two flops per pin, three on the address strobe for edge detection; address lines ride along so they stay aligned with the strobe
    always_ff @(posedge CLK) begin
        if (RST) begin
            sel_s1_r <= 1'b1;
            sel_s2_r <= 1'b1;
            shared_memory_request_s1_r <= 1'b1;
            shared_memory_request_s2_r <= 1'b1;
            sas_s1_r <= 1'b0;
            sas_s2_r <= 1'b0;
            sas_s3_r <= 1'b0;
            sds_s1_r <= 1'b1;
            sds_s2_r <= 1'b1;
            dir_s1_r <= 1'b0;
            dir_s2_r <= 1'b0;
            addr_s1_r <= SRAP_ADDR_RST;
            addr_s2_r <= SRAP_ADDR_RST;
        end else begin
            sel_s1_r <= bus.reg_port_sel_n;
            sel_s2_r <= sel_s1_r;
            shared_memory_request_s1_r <= bus.shared_memory_request_n;
            shared_memory_request_s2_r <= shared_memory_request_s1_r;
            sas_s1_r <= bus.slave_addr_strobe;
            sas_s2_r <= sas_s1_r;
            sas_s3_r <= sas_s2_r;
            sds_s1_r <= bus.slave_data_strobe_n;
            sds_s2_r <= sds_s1_r;
            dir_s1_r <= bus.slave_dir;
            dir_s2_r <= dir_s1_r;
            addr_s1_r <= bus.reg_addr_lines;
            addr_s2_r <= addr_s1_r;
        end
    end

    // ************************************************************
    // Access sequencer
    // ************************************************************
    srap_dev_state_type state_r;
    srap_dev_state_type state_nxt;
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] addr_nxt;
    logic wr_stb_r;
    logic wr_stb_nxt;
    logic rd_stb_r;
    logic rd_stb_nxt;
    logic [DATA_W-1:0] wdata_r;
    logic [DATA_W-1:0] wdata_nxt;
    logic [DATA_W-1:0] dout_r;
    logic [DATA_W-1:0] dout_nxt;
    logic doe_r;
    logic doe_nxt;
    logic ack_nxt;
    logic [1:0] size_ack_n_r;
    logic [1:0] size_ack_n_nxt;
    logic size_ack_oe_r;
    logic size_ack_oe_nxt;
    logic ready_r;
    logic ready_nxt;
    logic ready_oe_r;
    logic ready_oe_nxt;
    logic conflict_r;
    logic conflict_nxt;

    // Next state and pin values; select high in the address or ack state aborts back to idle
    always_comb begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        wr_stb_nxt = 1'b0;
        rd_stb_nxt = 1'b0;
        wdata_nxt = wdata_r;
        dout_nxt = dout_r;
        doe_nxt = doe_r;
        ack_nxt = 1'b0;
        case (state_r)
            SRAP_DS_IDLE: begin
                // Latch edge depends on style: fall in style 1, rise in style 0
                if (!sel_s2_r && srap_strobe_capture(sas_s3_r, sas_s2_r, style)) begin
                    addr_nxt = addr_s2_r;
                    state_nxt = SRAP_DS_ADDR;
                end
            end
            SRAP_DS_ADDR: begin
                if (sel_s2_r) begin
                    state_nxt = SRAP_DS_IDLE;
                end else if (!sds_s2_r) begin
                    if (srap_dir_is_read(dir_s2_r, style)) begin
                        rd_stb_nxt = 1'b1;
                        state_nxt = SRAP_DS_RDREQ;
                    end else begin
                        wr_stb_nxt = 1'b1;
                        wdata_nxt = bus.data_bus;
                        ack_nxt = 1'b1;
                        state_nxt = SRAP_DS_ACK;
                    end
                end
            end
            SRAP_DS_RDREQ: begin
                // Register file answers in the cycle its read strobe is high
                dout_nxt = REG_RD_DATA;
                doe_nxt = 1'b1;
                ack_nxt = 1'b1;
                state_nxt = SRAP_DS_ACK;
            end
            SRAP_DS_ACK: begin
                if (sel_s2_r || sds_s2_r) begin
                    doe_nxt = 1'b0;
                    state_nxt = SRAP_DS_IDLE;
                end else begin
                    ack_nxt = 1'b1;
                end
            end
            default: begin
                doe_nxt = 1'b0;
                state_nxt = SRAP_DS_IDLE;
            end
        endcase
        // Acknowledge pins are driven only while a slave cycle is open
        size_ack_n_nxt = (ack_nxt && style) ? SRAP_SIZE_ACK_ON : SRAP_SIZE_ACK_OFF;
        size_ack_oe_nxt = style && (state_nxt != SRAP_DS_IDLE);
        ready_nxt = ack_nxt && !style;
        ready_oe_nxt = !style && (state_nxt != SRAP_DS_IDLE);
    end

    // Overlap of the two selects is a host fault; kept sticky for inspection
    always_comb begin
        conflict_nxt = conflict_r || (!sel_s2_r && !shared_memory_request_s2_r);
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_r <= SRAP_DS_IDLE;
            addr_r <= SRAP_ADDR_RST;
            wr_stb_r <= 1'b0;
            rd_stb_r <= 1'b0;
            wdata_r <= SRAP_DATA_RST;
            dout_r <= SRAP_DATA_RST;
            doe_r <= 1'b0;
            size_ack_n_r <= SRAP_SIZE_ACK_OFF;
            size_ack_oe_r <= 1'b0;
            ready_r <= 1'b0;
            ready_oe_r <= 1'b0;
            conflict_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            wr_stb_r <= wr_stb_nxt;
            rd_stb_r <= rd_stb_nxt;
            wdata_r <= wdata_nxt;
            dout_r <= dout_nxt;
            doe_r <= doe_nxt;
            size_ack_n_r <= size_ack_n_nxt;
            size_ack_oe_r <= size_ack_oe_nxt;
            ready_r <= ready_nxt;
            ready_oe_r <= ready_oe_nxt;
            conflict_r <= conflict_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // All straight from flops
    assign bus.dev_data_out = dout_r;
    assign bus.dev_data_oe = doe_r;
    assign bus.slave_size_ack_n = size_ack_n_r;
    assign bus.size_ack_oe = size_ack_oe_r;
    assign bus.slave_ready_out = ready_r;
    assign bus.ready_oe = ready_oe_r;
    assign REG_ADDR = addr_r;
    assign REG_WR_STB = wr_stb_r;
    assign REG_WR_DATA = wdata_r;
    assign REG_RD_STB = rd_stb_r;
    assign PORT_CONFLICT = conflict_r;

endmodule : srap_device

// file: srap_host.sv
// Register access port master: the host end that drives select, strobes and data.
// Assumes the device acknowledges every access; there is no timeout.
`timescale 1ns/1ns
module srap_host import srap_pkg::*; #(
    parameter int ADDR_W = SRAP_ADDR_W,
    parameter int DATA_W = SRAP_DATA_W
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Device pins
    srap_if.host bus,
    // Register command
    input wire logic CMD_VALID,
    input wire logic CMD_WRITE,
    input wire logic [ADDR_W-1:0] CMD_ADDR,
    input wire logic [DATA_W-1:0] CMD_WDATA,
    output logic CMD_READY,
    output logic RSP_DONE,
    output logic [DATA_W-1:0] RSP_RDATA,
    // Shared memory path
    input wire logic MEM_WANT,
    output logic MEM_GRANTED
);

    // ************************************************************
    // Cycle sequencer
    // ************************************************************
    srap_host_state_type state_r;
    srap_host_state_type state_nxt;
    logic sel_n_r, sel_n_nxt;
    logic shared_memory_request_n_r, shared_memory_request_n_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic sas_r, sas_nxt;
    logic sds_n_r, sds_n_nxt;
    logic dir_r, dir_nxt;
    logic [DATA_W-1:0] hdata_r, hdata_nxt;
    logic hoe_r, hoe_nxt;
    logic is_read_r, is_read_nxt;
    logic [1:0] gap_r, gap_nxt;
    logic ready_r, ready_nxt;
    logic done_r, done_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic ack;
    logic style;

    assign style = bus.bus_style_select;
    // Style 1 ends on both size acks low, style 0 on ready
    assign ack = style ? (bus.size_ack_seen_n == SRAP_SIZE_ACK_ON) : bus.ready_seen;

    // Register access has priority over memory; both pass through the gap state
    always_comb begin
        state_nxt = state_r;
        sel_n_nxt = sel_n_r;
        shared_memory_request_n_nxt = shared_memory_request_n_r;
        addr_nxt = addr_r;
        sas_nxt = sas_r;
        sds_n_nxt = sds_n_r;
        dir_nxt = dir_r;
        hdata_nxt = hdata_r;
        hoe_nxt = hoe_r;
        is_read_nxt = is_read_r;
        gap_nxt = gap_r;
        done_nxt = 1'b0;
        rdata_nxt = rdata_r;
        case (state_r)
            SRAP_HS_IDLE: begin
                sas_nxt = srap_strobe_idle(style);
                if (CMD_VALID) begin
                    sel_n_nxt = 1'b0;
                    addr_nxt = CMD_ADDR;
                    is_read_nxt = !CMD_WRITE;
                    dir_nxt = srap_dir_level(!CMD_WRITE, style);
                    hdata_nxt = CMD_WDATA;
                    state_nxt = SRAP_HS_SETUP;
                end else if (MEM_WANT) begin
                    shared_memory_request_n_nxt = 1'b0;
                    state_nxt = SRAP_HS_MEM;
                end
            end
            SRAP_HS_SETUP: begin
                sas_nxt = !srap_strobe_idle(style);
                state_nxt = SRAP_HS_STROBE;
            end
            SRAP_HS_STROBE: begin
                sds_n_nxt = 1'b0;
                hoe_nxt = !is_read_r;
                state_nxt = SRAP_HS_DATA;
            end
            SRAP_HS_DATA: begin
                if (ack) begin
                    rdata_nxt = is_read_r ? bus.data_bus : rdata_r;
                    done_nxt = 1'b1;
                    sel_n_nxt = 1'b1;
                    sds_n_nxt = 1'b1;
                    hoe_nxt = 1'b0;
                    sas_nxt = srap_strobe_idle(style);
                    state_nxt = SRAP_HS_END;
                end
            end
            SRAP_HS_END: begin
                // Wait for the device to leave the bus before counting the gap
                if (!ack) begin
                    gap_nxt = SRAP_GAP_LAST;
                    state_nxt = SRAP_HS_GAP;
                end
            end
            SRAP_HS_MEM: begin
                if (!MEM_WANT) begin
                    shared_memory_request_n_nxt = 1'b1;
                    gap_nxt = SRAP_GAP_LAST;
                    state_nxt = SRAP_HS_GAP;
                end
            end
            SRAP_HS_GAP: begin
                if (gap_r == SRAP_GAP_ZERO) begin
                    state_nxt = SRAP_HS_IDLE;
                end else begin
                    gap_nxt = gap_r - 2'h1;
                end
            end
            default: begin
                state_nxt = SRAP_HS_IDLE;
            end
        endcase
        ready_nxt = (state_nxt == SRAP_HS_IDLE) && !(state_r == SRAP_HS_IDLE && CMD_VALID);
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_r <= SRAP_HS_IDLE;
            sel_n_r <= 1'b1;
            shared_memory_request_n_r <= 1'b1;
            addr_r <= SRAP_ADDR_RST;
            sas_r <= 1'b0;
            sds_n_r <= 1'b1;
            dir_r <= 1'b0;
            hdata_r <= SRAP_DATA_RST;
            hoe_r <= 1'b0;
            is_read_r <= 1'b0;
            gap_r <= SRAP_GAP_ZERO;
            ready_r <= 1'b0;
            done_r <= 1'b0;
            rdata_r <= SRAP_DATA_RST;
        end else begin
            state_r <= state_nxt;
            sel_n_r <= sel_n_nxt;
            shared_memory_request_n_r <= shared_memory_request_n_nxt;
            addr_r <= addr_nxt;
            sas_r <= sas_nxt;
            sds_n_r <= sds_n_nxt;
            dir_r <= dir_nxt;
            hdata_r <= hdata_nxt;
            hoe_r <= hoe_nxt;
            is_read_r <= is_read_nxt;
            gap_r <= gap_nxt;
            ready_r <= ready_nxt;
            done_r <= done_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign bus.reg_port_sel_n = sel_n_r;
    assign bus.shared_memory_request_n = shared_memory_request_n_r;
    assign bus.reg_addr_lines = addr_r;
    assign bus.slave_addr_strobe = sas_r;
    assign bus.slave_data_strobe_n = sds_n_r;
    assign bus.slave_dir = dir_r;
    assign bus.host_data_out = hdata_r;
    assign bus.host_data_oe = hoe_r;
    assign CMD_READY = ready_r;
    assign RSP_DONE = done_r;
    assign RSP_RDATA = rdata_r;
    assign MEM_GRANTED = !shared_memory_request_n_r;

endmodule : srap_host

// file: srap_if.sv
// Pin bundle between the host master and the register port slave.
// Assumes the testbench supplies the clock and the static bus style strap.
`timescale 1ns/1ns
interface srap_if import srap_pkg::*; (
    input wire logic CLK,
    input wire logic bus_style_select
);
    logic reg_port_sel_n;
    logic shared_memory_request_n;
    logic [SRAP_ADDR_W-1:0] reg_addr_lines;
    logic slave_addr_strobe;
    logic slave_data_strobe_n;
    logic slave_dir;
    logic [SRAP_DATA_W-1:0] host_data_out;
    logic host_data_oe;
    logic [SRAP_DATA_W-1:0] dev_data_out;
    logic dev_data_oe;
    logic [1:0] slave_size_ack_n;
    logic size_ack_oe;
    logic slave_ready_out;
    logic ready_oe;
    logic [SRAP_DATA_W-1:0] data_bus;
    logic [1:0] size_ack_seen_n;
    logic ready_seen;

    // Wire levels; undriven lines rest at their inactive level
    assign data_bus = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : '0);
    assign size_ack_seen_n = size_ack_oe ? slave_size_ack_n : SRAP_SIZE_ACK_OFF;
    assign ready_seen = ready_oe & slave_ready_out;

    modport device (
        input CLK, bus_style_select, reg_port_sel_n, shared_memory_request_n,
        input reg_addr_lines, slave_addr_strobe, slave_data_strobe_n, slave_dir, data_bus,
        output dev_data_out, dev_data_oe, slave_size_ack_n, size_ack_oe,
        output slave_ready_out, ready_oe
    );

    modport host (
        input CLK, bus_style_select, data_bus, size_ack_seen_n, ready_seen,
        output reg_port_sel_n, shared_memory_request_n, reg_addr_lines,
        output slave_addr_strobe, slave_data_strobe_n, slave_dir, host_data_out, host_data_oe
    );
endinterface : srap_if

// file: srap_pkg.sv
// Shared constants, types and helpers for both ends of the register access port.
// Assumes one bus clock for both ends and a static bus style strap.
package srap_pkg;

    // ************************************************************
    // Widths and timing
    // ************************************************************
    localparam int SRAP_ADDR_W = 6;
    localparam int SRAP_DATA_W = 16;
    // Least bus clocks between releasing one select and asserting the other
    localparam int SRAP_GAP_CLKS = 2;
    localparam logic [1:0] SRAP_GAP_LAST = 2'h1;
    localparam logic [1:0] SRAP_GAP_ZERO = 2'h0;

    // ************************************************************
    // Pin levels
    // ************************************************************
    localparam logic [1:0] SRAP_SIZE_ACK_ON = 2'h0;
    localparam logic [1:0] SRAP_SIZE_ACK_OFF = 2'h3;
    localparam logic [SRAP_ADDR_W-1:0] SRAP_ADDR_RST = 6'h00;
    localparam logic [SRAP_DATA_W-1:0] SRAP_DATA_RST = 16'h0000;

    // ************************************************************
    // State encodings
    // ************************************************************
    typedef enum logic [1:0] {
        SRAP_DS_IDLE = 2'h0,
        SRAP_DS_ADDR = 2'h1,
        SRAP_DS_RDREQ = 2'h2,
        SRAP_DS_ACK = 2'h3
    } srap_dev_state_type;

    typedef enum logic [2:0] {
        SRAP_HS_IDLE = 3'h0,
        SRAP_HS_SETUP = 3'h1,
        SRAP_HS_STROBE = 3'h2,
        SRAP_HS_DATA = 3'h3,
        SRAP_HS_END = 3'h4,
        SRAP_HS_GAP = 3'h5,
        SRAP_HS_MEM = 3'h6
    } srap_host_state_type;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Address strobe rests high in style 1 and low in style 0
    function automatic logic srap_strobe_idle(input logic style);
        return style;
    endfunction : srap_strobe_idle

    // Capture edge: leaving the rest level of the address strobe
    function automatic logic srap_strobe_capture(input logic prev, input logic cur,
                                                 input logic style);
        return (prev == srap_strobe_idle(style)) && (cur != srap_strobe_idle(style));
    endfunction : srap_strobe_capture

    // Direction pin level: style 1 high for read, style 0 low for read
    function automatic logic srap_dir_level(input logic is_read, input logic style);
        return is_read ? style : ~style;
    endfunction : srap_dir_level

    function automatic logic srap_dir_is_read(input logic dir, input logic style);
        return dir == style;
    endfunction : srap_dir_is_read

endpackage : srap_pkg

// file: tb_slave_register_access_port.sv
// Testbench: host and device ends joined, plus a hand-driven device bus.
// Assumes the strap changes only while reset is held.
`timescale 1ns/1ns
module tb_slave_register_access_port import srap_pkg::*; ;
    logic clk, rst, style, cmd_valid, cmd_write, cmd_ready, rsp_done, mem_want, mem_granted;
    logic [SRAP_ADDR_W-1:0] cmd_addr, reg_addr, f_addr;
    logic [SRAP_DATA_W-1:0] cmd_wdata, rsp_rdata, wr_data, rd_data;
    logic wr_stb, rd_stb, f_wr_stb, conflict, f_conflict;
    int miscompares = 0, n_compared = 0, cycles = 0, wr_cnt = 0, rd_cnt = 0, f_cnt = 0;
    // ****
    // Ends under test; f_if carries deliberate host faults
    // ****
    srap_if bus_if (.CLK(clk), .bus_style_select(style));
    srap_if f_if (.CLK(clk), .bus_style_select(style));
    assign rd_data = {10'h2a5, reg_addr};
    srap_device u_srap_device (.CLK(clk), .RST(rst), .bus(bus_if.device), .REG_ADDR(reg_addr),
        .REG_WR_STB(wr_stb), .REG_WR_DATA(wr_data), .REG_RD_STB(rd_stb), .REG_RD_DATA(rd_data),
        .PORT_CONFLICT(conflict));
    srap_host u_srap_host (.CLK(clk), .RST(rst), .bus(bus_if.host), .CMD_VALID(cmd_valid),
        .CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata), .CMD_READY(cmd_ready),
        .RSP_DONE(rsp_done), .RSP_RDATA(rsp_rdata), .MEM_WANT(mem_want), .MEM_GRANTED(mem_granted));
    srap_device u_srap_device_f (.CLK(clk), .RST(rst), .bus(f_if.device), .REG_ADDR(f_addr),
        .REG_WR_STB(f_wr_stb), .REG_WR_DATA(), .REG_RD_STB(), .REG_RD_DATA(16'h0000),
        .PORT_CONFLICT(f_conflict));
    srap_assertions u_srap_assertions (.CLK(clk), .RST(rst), .bus_style_select(style),
        .reg_port_sel_n(bus_if.reg_port_sel_n),
        .shared_memory_request_n(bus_if.shared_memory_request_n),
        .reg_addr_lines(bus_if.reg_addr_lines), .slave_data_strobe_n(bus_if.slave_data_strobe_n),
        .slave_dir(bus_if.slave_dir), .dev_data_oe(bus_if.dev_data_oe),
        .size_ack_seen_n(bus_if.size_ack_seen_n), .ready_seen(bus_if.ready_seen));
    // Clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Strobe counters and hang guard; ceiling far above the run length
    always @(posedge clk) begin
        cycles++;
        if (wr_stb === 1'b1) wr_cnt++;
        if (rd_stb === 1'b1) rd_cnt++;
        if (f_wr_stb === 1'b1) f_cnt++;
        if (cycles == 20000) begin
            miscompares++;
            $display("CHECK FAILED at %0t: timeout", $time);
            close_out();
        end
    end
    // ****
    // Shared tasks
    // ****
    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    // Strap changes only under reset so the device never sees a false edge
    task automatic do_reset(input logic s);
        rst = 1'b1;
        style = s;
        f_if.slave_addr_strobe = s;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (6) @(negedge clk);
        chk(conflict === 1'b0 && f_conflict === 1'b0 && wr_stb === 1'b0, "reset state");
    endtask : do_reset
    task automatic run_cmd(input logic wr, input logic [5:0] a, input logic [15:0] d);
        int i;
        for (i = 0; i < 60 && cmd_ready !== 1'b1; i++) @(negedge clk);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_addr = a;
        cmd_wdata = d;
        @(negedge clk);
        cmd_valid = 1'b0;
        for (i = 0; i < 60 && rsp_done !== 1'b1; i++) @(negedge clk);
        chk(rsp_done === 1'b1, "no completion");
    endtask : run_cmd
    // ****
    // Scenarios
    // ****
    // Boundary and alternating-bit addresses, back to back write and read
    task automatic t_write_read();
        logic [5:0] tbl[3] = '{6'h00, 6'h3f, 6'h2a};
        int n, m;
        foreach (tbl[k]) begin
            n = wr_cnt;
            m = rd_cnt;
            run_cmd(1'b1, tbl[k], {tbl[k], 10'h35a});
            chk(wr_cnt == n + 1 && reg_addr === tbl[k], "write address");
            chk(wr_data === {tbl[k], 10'h35a} && rd_cnt == m, "write data");
            run_cmd(1'b0, tbl[k], 16'h0000);
            chk(rsp_rdata === {10'h2a5, tbl[k]} && wr_cnt == n + 1, "read data");
            chk(rd_cnt == m + 1, "read strobe count");
        end
    endtask : t_write_read
    // Memory request then register access at once, and back
    task automatic t_mem_swap();
        int i;
        mem_want = 1'b1;
        for (i = 0; i < 20 && mem_granted !== 1'b1; i++) @(negedge clk);
        chk(bus_if.shared_memory_request_n === 1'b0 && bus_if.reg_port_sel_n === 1'b1, "mem");
        mem_want = 1'b0;
        run_cmd(1'b1, 6'h11, 16'hbeef);
        chk(reg_addr === 6'h11 && wr_data === 16'hbeef, "write after memory");
        mem_want = 1'b1;
        for (i = 0; i < 20 && mem_granted !== 1'b1; i++) @(negedge clk);
        chk(mem_granted === 1'b1, "memory after write");
        mem_want = 1'b0;
        repeat (4) @(negedge clk);
    endtask : t_mem_swap
    // Pin-level write on the fault bus, with or without select
    task automatic f_write(input logic sel, input logic [5:0] a);
        int n;
        n = f_cnt;
        f_if.reg_port_sel_n = ~sel;
        f_if.reg_addr_lines = a;
        f_if.slave_dir = ~style;
        @(negedge clk);
        f_if.slave_addr_strobe = ~style;
        @(negedge clk);
        f_if.host_data_oe = 1'b1;
        f_if.slave_data_strobe_n = 1'b0;
        repeat (8) @(negedge clk);
        f_if.reg_port_sel_n = 1'b1;
        f_if.slave_addr_strobe = style;
        f_if.slave_data_strobe_n = 1'b1;
        f_if.host_data_oe = 1'b0;
        repeat (5) @(negedge clk);
        chk(f_cnt == n + int'(sel), "strobe count on fault bus");
        chk(!sel || f_addr === a, "address edge capture");
    endtask : f_write
    task automatic t_fault();
        f_write(1'b0, 6'h07);
        f_write(1'b1, 6'h38);
        chk(f_conflict === 1'b0, "false conflict");
        f_if.reg_port_sel_n = 1'b0;
        f_if.shared_memory_request_n = 1'b0;
        repeat (5) @(negedge clk);
        chk(f_conflict === 1'b1, "overlap not flagged");
        f_if.reg_port_sel_n = 1'b1;
        f_if.shared_memory_request_n = 1'b1;
    endtask : t_fault
    // ****
    // Main sequence
    // ****
    initial begin
        {rst, style, cmd_valid, cmd_write, mem_want} = 5'h10;
        cmd_addr = 6'h00;
        cmd_wdata = 16'h0000;
        {f_if.reg_port_sel_n, f_if.shared_memory_request_n, f_if.slave_data_strobe_n} = 3'h7;
        {f_if.slave_addr_strobe, f_if.slave_dir, f_if.host_data_oe} = 3'h4;
        f_if.reg_addr_lines = 6'h00;
        f_if.host_data_out = 16'h5ac3;
        for (int s = 1; s >= 0; s--) begin
            do_reset(s[0]);
            t_write_read();
            t_mem_swap();
            t_fault();
        end
        close_out();
    end
endmodule : tb_slave_register_access_port
